// ### verilog/alu_pkg.sv
// Package for the accumulator datapath subset: register map, field layout,
// operation codes and reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package alu_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ctrl_off   = 8'h00; // Write: operation command
   localparam logic [7:0] acc_off    = 8'h04; // Working accumulator
   localparam logic [7:0] flags_off  = 8'h08; // Status flags
   localparam logic [7:0] pc_off     = 8'h0c; // Program counter
   localparam logic [7:0] stack_off  = 8'h10; // Return stack top
   localparam logic [7:0] fidx_off   = 8'h14; // File register index
   localparam logic [7:0] fdata_off  = 8'h18; // File register data at index

   // ************************************************************
   // Command word fields
   // ************************************************************
   localparam int op_lsb    = 0;   // 4-bit operation code
   localparam int dest_bit  = 4;   // Destination select
   localparam int bit_lsb   = 5;   // 3-bit bit index
   localparam int addr_lsb  = 8;   // 7-bit file address
   localparam int lit_lsb   = 16;  // 8-bit literal

   // Flag register bit positions
   localparam int carry_pos = 0;
   localparam int half_pos  = 1;
   localparam int zero_pos  = 2;
   localparam int gie_pos   = 3;

   // ************************************************************
   // Sizes and reset values
   // ************************************************************
   localparam int          file_depth = 128;
   localparam int          pc_width   = 13;
   localparam logic [7:0]  acc_rst    = 8'h00;
   localparam logic [12:0] pc_rst     = 13'h0000;

   typedef enum logic [3:0] {
      nop_op               = 4'h0,
      add_immediate_op     = 4'h1,
      add_register_op      = 4'h2,
      and_register_op      = 4'h3,
      and_immediate_op     = 4'h4,
      bit_clear_op         = 4'h5,
      bit_set_op           = 4'h6,
      rotate_left_op       = 4'h7,
      interrupt_return_op  = 4'h8
   } op_t;

endpackage

// ### verilog/alu_if.sv
// Interface joining the execution core to its arithmetic unit.
// Assumes both ends run in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
interface alu_if;
   logic [3:0] op;
   logic [7:0] acc;
   logic [7:0] fval;
   logic [7:0] lit;
   logic [2:0] bsel;
   logic       carry_in;
   logic [7:0] result;
   logic       carry_out;
   logic       half_out;
   logic       zero_out;
   modport core (output op, acc, fval, lit, bsel, carry_in,
                 input result, carry_out, half_out, zero_out);
   modport unit (input op, acc, fval, lit, bsel, carry_in,
                 output result, carry_out, half_out, zero_out);
endinterface
`default_nettype wire

// ### verilog/alu_unit.sv
// Combinational arithmetic unit: add, AND, bit clear/set, rotate left.
// Assumes operands are stable from the core for the whole cycle.
`timescale 1ns/100ps
`default_nettype none
module alu_unit
   import alu_pkg::*;
(
   alu_if.unit u
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] mask;
   logic [7:0] opnd;

   // ************************************************************
   // Operation select
   // ************************************************************
   always_comb begin
      opnd        = (u.op == add_immediate_op || u.op == and_immediate_op) ? u.lit : u.fval;
      sum         = {1'b0, u.acc} + {1'b0, opnd};
      nib         = {1'b0, u.acc[3:0]} + {1'b0, opnd[3:0]};
      mask        = 8'h01 << u.bsel;
      u.carry_out = u.carry_in;
      u.half_out  = 1'b0;
      case (u.op)
         add_immediate_op, add_register_op: begin
            u.result    = sum[7:0];                  // see RQ1 see RQ2
            u.carry_out = sum[8];
            u.half_out  = nib[4];
         end
         and_register_op, and_immediate_op: begin
            u.result = u.acc & opnd;                 // see RQ4 see RQ5
         end
         bit_clear_op:   u.result = u.fval & ~mask;  // see RQ6
         bit_set_op:     u.result = u.fval | mask;   // see RQ7
         rotate_left_op: begin
            u.result    = {u.fval[6:0], u.carry_in}; // see RQ8
            u.carry_out = u.fval[7];
         end
         default:        u.result = u.fval;
      endcase
      u.zero_out = (u.result == 8'h00);
   end
endmodule
`default_nettype wire

// ### verilog/alu_core.sv
// Execution datapath for a subset of an 8-bit accumulator instruction set,
// with an APB slave for commands and state readback.
// Assumes a single clock pclk and an APB master in the same domain.
//
// How it works
// RQ1 - Add immediate: accumulator plus literal to accumulator; carry, half, zero.
// RQ2 - Add register: accumulator plus file register; carry, half, zero updated.
// RQ3 - Destination select 0 writes accumulator, 1 writes file register.
// RQ4 - AND register: accumulator AND file register, routed; only zero changes.
// RQ5 - AND immediate: accumulator AND literal into accumulator; only zero changes.
// RQ6 - Bit clear forces one file bit low; flags untouched.
// RQ7 - Bit set forces one file bit high; flags untouched.
// RQ8 - Rotate left through carry; old bit 7 becomes carry; routed.
// RQ9 - Interrupt return loads PC from stack top, sets interrupt enable.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module alu_core
   import alu_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   typedef struct packed {
      logic [7:0]              acc;
      logic                    carry;
      logic                    half;
      logic                    zero;
      logic                    global_interrupt_enable;
      logic [pc_width-1:0]     pc;
      logic [pc_width-1:0]     stack_top;
      logic [6:0]              fidx;
      logic [file_depth-1:0][7:0] file;
      logic [31:0]             rdata;
      logic                    err;
   } state_t;

   state_t st_q;
   state_t st_d;

   alu_if au ();

   alu_unit u_unit (
      .u (au.unit)
   );

   logic       wr_acc;
   logic       rd_acc;
   logic [3:0] cmd_op;
   logic [6:0] cmd_addr;
   logic       cmd_dest;

   // ************************************************************
   // Bus decode
   // ************************************************************
   // Single-cycle access phase keeps the slave simple; never stalls
   assign pready  = 1'b1;
   assign prdata  = st_q.rdata;
   assign pslverr = st_q.err;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && !penable && !pwrite;

   assign cmd_op   = pwdata[op_lsb +: 4];
   assign cmd_addr = pwdata[addr_lsb +: 7];
   assign cmd_dest = pwdata[dest_bit];

   // Literal, bit index and file address come straight from the command word, op only on a command write (else nop); accumulator and carry from state
   assign au.op       = (wr_acc && paddr == ctrl_off) ? cmd_op : nop_op;
   assign au.acc      = st_q.acc;
   assign au.fval     = st_q.file[cmd_addr];
   assign au.lit      = pwdata[lit_lsb +: 8];
   assign au.bsel     = pwdata[bit_lsb +: 3];
   assign au.carry_in = st_q.carry;

   // ************************************************************
   // Next state
   // ************************************************************
   // Read data is captured in the setup phase, so pslverr/prdata are
   // registered and valid in the access phase.
   always_comb begin
      st_d = st_q;
      if (psel && !penable) begin
         st_d.err = !(paddr inside {ctrl_off, acc_off, flags_off, pc_off,
                                     stack_off, fidx_off, fdata_off});
      end
      if (rd_acc) begin
         case (paddr)
            acc_off:   st_d.rdata = {24'h0, st_q.acc};
            flags_off: st_d.rdata = {28'h0, st_q.global_interrupt_enable, st_q.zero, st_q.half, st_q.carry};
            pc_off:    st_d.rdata = {19'h0, st_q.pc};
            stack_off: st_d.rdata = {19'h0, st_q.stack_top};
            fidx_off:  st_d.rdata = {25'h0, st_q.fidx};
            fdata_off: st_d.rdata = {24'h0, st_q.file[st_q.fidx]};
            default:   st_d.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            acc_off:   st_d.acc = pwdata[7:0];
            flags_off: begin
               st_d.carry = pwdata[carry_pos];
               st_d.half  = pwdata[half_pos];
               st_d.zero  = pwdata[zero_pos];
               st_d.global_interrupt_enable   = pwdata[gie_pos];
            end
            stack_off: st_d.stack_top = pwdata[pc_width-1:0];
            fidx_off:  st_d.fidx = pwdata[6:0];
            fdata_off: st_d.file[st_q.fidx] = pwdata[7:0];
            ctrl_off: begin
               case (op_t'(cmd_op))
                  add_immediate_op: begin
                     st_d.acc   = au.result;             // see RQ1
                     st_d.carry = au.carry_out;
                     st_d.half  = au.half_out;
                     st_d.zero  = au.zero_out;
                  end
                  add_register_op, and_register_op, rotate_left_op: begin
                     if (cmd_dest) begin                 // see RQ3
                        st_d.file[cmd_addr] = au.result;
                     end else begin
                        st_d.acc = au.result;
                     end
                     st_d.zero = au.zero_out;            // see RQ2 see RQ4
                     if (cmd_op == add_register_op) begin
                        st_d.carry = au.carry_out;       // see RQ2
                        st_d.half  = au.half_out;
                     end
                     if (cmd_op == rotate_left_op) begin
                        st_d.zero  = st_q.zero;          // see RQ8
                        st_d.carry = au.carry_out;
                     end
                  end
                  and_immediate_op: begin
                     st_d.acc  = au.result;              // see RQ5
                     st_d.zero = au.zero_out;
                  end
                  bit_clear_op, bit_set_op: begin
                     st_d.file[cmd_addr] = au.result;    // see RQ6 see RQ7
                  end
                  interrupt_return_op: begin
                     st_d.pc  = st_q.stack_top;          // see RQ9
                     st_d.global_interrupt_enable = 1'b1;
                  end
                  default: st_d.pc = st_q.pc;
               endcase
               // Each command with a code from 1 to 7 advances the PC; nop, the return and undefined codes do not
               if (cmd_op != interrupt_return_op && cmd_op <= rotate_left_op &&
                   cmd_op != nop_op) begin
                  st_d.pc = st_q.pc + 13'h0001;
               end
            end
            default: st_d.err = st_q.err;
         endcase
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule
`default_nettype wire

// ### verification/alu_core_sva.sv
// Checker for the datapath's APB slave port.
// Assumes it is bound to alu_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module alu_core_sva
   import alu_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ************************************************
   // Transfer phases
   // ************************************************
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_s(logic [7:0] a);
      setup_s ##0 (!pwrite && paddr == a);
   endsequence

   // Zero wait states, so a master never stalls
   AST_READY_HIGH: assert property (psel |-> pready) else $error("pready low");
   // Errors only on holes in the map; mapped words must never flag one
   AST_UNMAPPED_ERR: assert property (setup_s ##0 paddr > 8'h18 |=> pslverr)
      else $error("no error on unmapped address");
   AST_MAPPED_OK: assert property (setup_s ##0 (paddr <= 8'h18 && paddr[1:0] == 2'b00)
      |=> !pslverr) else $error("error on mapped address");
   // Answer stands until the next setup cycle
   AST_ANSWER_HOLDS: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
      else $error("answer changed outside setup");
   AST_CTRL_READS_ZERO: assert property (rd_s(ctrl_off) |=> prdata == 32'h0)
      else $error("command word read back");
   AST_ACC_WIDTH: assert property (rd_s(acc_off) |=> prdata[31:8] == 24'h0)
      else $error("accumulator wider than 8 bits");
   AST_FILE_WIDTH: assert property (rd_s(fdata_off) |=> prdata[31:8] == 24'h0)
      else $error("file register wider than 8 bits");
   AST_FLAGS_WIDTH: assert property (rd_s(flags_off) |=> prdata[31:4] == 28'h0)
      else $error("flags word has stray bits");
   AST_PC_WIDTH: assert property (rd_s(pc_off) |=> prdata[31:13] == 19'h0)
      else $error("program counter too wide");
endmodule

bind alu_core alu_core_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr);
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for alu_core: commands and readback over APB.
// Assumes the checker is bound in from its own file.
`timescale 1ns/100ps
`default_nettype none
module tb
   import alu_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err_seen;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          b;

   always #50 pclk = ~pclk;

   alu_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);

   // ************************************************
   // Bus tasks
   // ************************************************
   // Request held until pready is seen; no fixed latency assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   task automatic exe(input op_t op, input logic d, input logic [2:0] bi,
                      input logic [6:0] fa, input logic [7:0] k);
      xfer(1'b1, ctrl_off, {8'h00, k, 1'b0, fa, bi, d, op});
   endtask
   // File access goes through the index register, so two writes
   task automatic setf(input logic [6:0] fa, input logic [7:0] v);
      xfer(1'b1, fidx_off, {25'h0, fa});
      xfer(1'b1, fdata_off, {24'h0, v});
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Cut a hang short; normal run needs well under a thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end

   // ************************************************
   // Scenarios
   // ************************************************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rc("acc", acc_off, 32'h0);
      rc("flags", flags_off, 32'h0);
      rc("pc", pc_off, 32'h0);
      rc("ctrl", ctrl_off, 32'h0);
      chk("slverr_ok", {31'h0, err_seen}, 32'h0);
      rc("hole", 8'h1c, 32'h0);
      chk("slverr", {31'h0, err_seen}, 32'h1);
      // Sum wraps to zero: all three flags at once
      xfer(1'b1, acc_off, 32'hf8);
      exe(add_immediate_op, 1'b0, 0, 0, 8'h08);
      rc("acc", acc_off, 32'h00);
      rc("flags", flags_off, 32'h7);
      exe(add_immediate_op, 1'b0, 0, 0, 8'h34);
      rc("acc", acc_off, 32'h34);
      rc("flags", flags_off, 32'h0);
      // Top file address, both destinations
      setf(7'h7f, 8'h0f);
      exe(add_register_op, 1'b0, 0, 7'h7f, 0);
      rc("acc", acc_off, 32'h43);
      rc("flags", flags_off, 32'h2);
      rc("file", fdata_off, 32'h0f);
      exe(add_register_op, 1'b1, 0, 7'h7f, 0);
      rc("file", fdata_off, 32'h52);
      rc("acc", acc_off, 32'h43);
      // Carry and half stay through the AND operations
      xfer(1'b1, flags_off, 32'h3);
      setf(7'h7f, 8'hbc);
      exe(and_register_op, 1'b1, 0, 7'h7f, 0);
      rc("file", fdata_off, 32'h00);
      rc("flags", flags_off, 32'h7);
      rc("acc", acc_off, 32'h43);
      exe(and_immediate_op, 1'b0, 0, 0, 8'h0f);
      rc("acc", acc_off, 32'h03);
      rc("flags", flags_off, 32'h3);
      for (b = 0; b < 8; b++) begin
         setf(7'h05, 8'hff);
         exe(bit_clear_op, 1'b0, b[2:0], 7'h05, 0);
         rc("clr", fdata_off, 32'hff & ~(32'h1 << b));
         setf(7'h05, 8'h00);
         exe(bit_set_op, 1'b0, b[2:0], 7'h05, 0);
         rc("set", fdata_off, 32'h1 << b);
      end
      rc("flags", flags_off, 32'h3);
      // Carry in enters bit 0, bit 7 leaves into carry
      xfer(1'b1, flags_off, 32'h1);
      setf(7'h03, 8'h80);
      exe(rotate_left_op, 1'b1, 0, 7'h03, 0);
      rc("file", fdata_off, 32'h01);
      rc("flags", flags_off, 32'h1);
      exe(rotate_left_op, 1'b0, 0, 7'h03, 0);
      rc("acc", acc_off, 32'h03);
      rc("flags", flags_off, 32'h0);
      rc("file", fdata_off, 32'h01);
      // Twenty-four executed commands so far, one PC step each
      rc("pc", pc_off, 32'h18);
      rc("fidx", fidx_off, 32'h03);
      xfer(1'b1, flags_off, 32'h7);
      xfer(1'b1, stack_off, 32'h1234);
      rc("stack", stack_off, 32'h1234);
      exe(interrupt_return_op, 1'b0, 0, 0, 0);
      rc("pc", pc_off, 32'h1234);
      rc("flags", flags_off, 32'hf);
      // Program counter is read-only over the bus
      xfer(1'b1, pc_off, 32'h0);
      rc("pc_ro", pc_off, 32'h1234);
      // Undefined code must leave state alone
      exe(op_t'(4'h9), 1'b0, 0, 0, 8'hff);
      rc("pc", pc_off, 32'h1234);
      rc("acc", acc_off, 32'h03);
      summarize();
   end
endmodule
`default_nettype wire
